// [design/opp_prog.sv]
`timescale 1ns/1ps
`include "opp_map.svh"
module opp_prog
  import opp_pkg::*;
#(
  parameter logic [`OPP_AW-1:0] LAST_ADDR = '1,
  parameter int PW_NS = `OPP_PW_NS,
  parameter int SETUP_NS = `OPP_SETUP_NS
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // user side
  input wire logic i_prog_start,
  input wire logic i_id_start,
  input wire logic [`OPP_DW-1:0] i_src_data,
  output logic o_busy,
  output logic o_done,
  output logic o_pass,
  output logic o_fail,
  output logic [`OPP_DW-1:0] o_mfr_code,
  output logic [`OPP_DW-1:0] o_dev_code,
  // part pins
  input wire logic [`OPP_DW-1:0] i_dq,
  output opp_pins_t o_pins
);
  localparam int TW = `OPP_TMR_W;
  localparam int PW_CYC = opp_cyc_up(PW_NS);
  localparam int PW_MIN_CYC = opp_cyc_up(`OPP_PW_MIN_NS);
  localparam int PW_MAX_CYC = opp_cyc_dn(`OPP_PW_MAX_NS);
  localparam int SU_CYC = opp_cyc_up(SETUP_NS);
  localparam int RD_CYC = opp_cyc_up(`OPP_OE_NS) + `OPP_SYNC_CYC;
  localparam int FLT_CYC = opp_cyc_up(`OPP_DFP_NS);
  localparam logic [TW-1:0] PW_LD = TW'(PW_CYC - 1);
  localparam logic [TW-1:0] SU_LD = TW'(SU_CYC - 1);
  localparam logic [TW-1:0] RD_LD = TW'(RD_CYC - 1);
  localparam logic [TW-1:0] FLT_LD = TW'(FLT_CYC - 1);

  if (PW_CYC < PW_MIN_CYC || PW_CYC > PW_MAX_CYC || PW_CYC >= (1 << TW)) begin : g_pw_chk
    $error("program pulse width outside its window");
  end
  if (SU_CYC < 2 || SU_CYC >= (1 << TW)) begin : g_su_chk
    $error("setup time unusable");
  end

  typedef enum logic [3:0] {
    S_IDLE, S_VCC_UP, S_VPP_UP, S_SET, S_PULSE, S_HOLD, S_OES, S_RD, S_FLT,
    S_VPP_DN, S_VCC_DN, S_VPP_OFF, S_VCC_OFF
  } opp_st_t;

  opp_st_t st_q;
  opp_phase_t phase_q;
  opp_pins_t pins_q;
  logic [`OPP_RETRY_W-1:0] retry_q;
  logic [`OPP_DW-1:0] dq_s1_q, dq_s2_q;
  logic ld_q, fire, match_q, busy_q, done_q, pass_q, fail_q;
  logic [TW-1:0] ld_cnt_q;
  logic [`OPP_DW-1:0] mfr_q, dev_q;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire last_w = (pins_q.addr == LAST_ADDR);
  wire match_w = (dq_s2_q == i_src_data);
  wire retry_out_w = (retry_q == `OPP_RETRY_MAX);
  wire code_sel_w = pins_q.addr[`OPP_CODE_SEL_BIT];
  wire next_ce_n_w = !(phase_q == PH_ID || phase_q == PH_FINAL);

  assign o_pins = pins_q;
  assign o_busy = busy_q;
  assign o_done = done_q;
  assign o_pass = pass_q;
  assign o_fail = fail_q;
  assign o_mfr_code = mfr_q;
  assign o_dev_code = dev_q;

  opp_timer #(.CW(TW)) u_tmr (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_load(ld_q),
    .i_count(ld_cnt_q),
    .o_fire(fire)
  );

  // data pins come from the part, outside our timing
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
    end else begin
      dq_s1_q <= i_dq;
      dq_s2_q <= dq_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q <= S_IDLE;
      phase_q <= PH_FIRST;
      pins_q <= '{addr: '0, ce_n: 1'b1, oe_n: 1'b1, dq_out: '0, dq_oe: 1'b0,
                  vcc: RAIL_OFF, vpp: RAIL_OFF, id_hv: 1'b0};
      retry_q <= '0;
      ld_q <= 1'b0;
      ld_cnt_q <= '0;
      match_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      pass_q <= 1'b0;
      fail_q <= 1'b0;
      mfr_q <= '0;
      dev_q <= '0;
    end else begin
      ld_q <= 1'b0;
      done_q <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (i_prog_start || i_id_start) begin
            phase_q <= i_prog_start ? PH_FIRST : PH_ID;
            pins_q.addr <= '0;
            pins_q.vcc <= i_prog_start ? RAIL_PROG : RAIL_NORM;
            retry_q <= '0;
            busy_q <= 1'b1;
            pass_q <= 1'b0;
            fail_q <= 1'b0;
            ld_q <= 1'b1;
            ld_cnt_q <= SU_LD;
            st_q <= S_VCC_UP;
          end
        end
        S_VCC_UP: if (fire) begin
          // rail follows the core supply after its setup time
          pins_q.vpp <= (phase_q == PH_ID) ? RAIL_NORM : RAIL_PROG;
          pins_q.id_hv <= (phase_q == PH_ID);
          ld_q <= 1'b1;
          ld_cnt_q <= SU_LD;
          st_q <= S_VPP_UP;
        end
        S_VPP_UP: if (fire) begin
          ld_q <= 1'b1;
          ld_cnt_q <= SU_LD;
          st_q <= (phase_q == PH_ID) ? S_OES : S_SET;
        end
        S_SET: begin
          pins_q.dq_out <= i_src_data;
          pins_q.dq_oe <= 1'b1;
          if (fire) begin
            pins_q.ce_n <= 1'b0;
            ld_q <= 1'b1;
            ld_cnt_q <= PW_LD;
            st_q <= S_PULSE;
          end
        end
        S_PULSE: if (fire) begin
          pins_q.ce_n <= 1'b1;
          ld_q <= 1'b1;
          ld_cnt_q <= SU_LD;
          st_q <= S_HOLD;
        end
        S_HOLD: if (fire) begin
          pins_q.dq_oe <= 1'b0;
          ld_q <= 1'b1;
          ld_cnt_q <= SU_LD;
          if (phase_q == PH_FIRST && !last_w) begin
            pins_q.addr <= pins_q.addr + `OPP_AW'(1);
            st_q <= S_SET;
          end else if (phase_q == PH_FIRST) begin
            phase_q <= PH_VERIFY;
            pins_q.addr <= '0;
            retry_q <= '0;
            st_q <= S_OES;
          end else begin
            st_q <= S_OES;
          end
        end
        S_OES: if (fire) begin
          pins_q.oe_n <= 1'b0;
          pins_q.ce_n <= next_ce_n_w;
          ld_q <= 1'b1;
          ld_cnt_q <= RD_LD;
          st_q <= S_RD;
        end
        S_RD: if (fire) begin
          // sampled only after the valid delay plus the synchroniser
          match_q <= match_w;
          if (phase_q == PH_ID && !code_sel_w) begin
            mfr_q <= dq_s2_q;
          end
          if (phase_q == PH_ID && code_sel_w) begin
            dev_q <= dq_s2_q;
          end
          pins_q.oe_n <= 1'b1;
          pins_q.ce_n <= 1'b1;
          ld_q <= 1'b1;
          ld_cnt_q <= FLT_LD;
          st_q <= S_FLT;
        end
        S_FLT: if (fire) begin
          ld_q <= 1'b1;
          ld_cnt_q <= SU_LD;
          case (phase_q)
            PH_ID: begin
              if (!code_sel_w) begin
                pins_q.addr[`OPP_CODE_SEL_BIT] <= 1'b1;
                st_q <= S_OES;
              end else begin
                pass_q <= 1'b1;
                pins_q.id_hv <= 1'b0;
                pins_q.vpp <= RAIL_OFF;
                st_q <= S_VPP_OFF;
              end
            end
            PH_VERIFY: begin
              if (match_q && last_w) begin
                phase_q <= PH_FINAL;
                pins_q.vpp <= RAIL_NORM;
                st_q <= S_VPP_DN;
              end else if (match_q) begin
                pins_q.addr <= pins_q.addr + `OPP_AW'(1);
                retry_q <= '0;
                st_q <= S_OES;
              end else if (retry_out_w) begin
                fail_q <= 1'b1;
                pins_q.vpp <= RAIL_OFF;
                st_q <= S_VPP_OFF;
              end else begin
                retry_q <= retry_q + `OPP_RETRY_W'(1);
                st_q <= S_SET;
              end
            end
            default: begin
              if (!match_q || last_w) begin
                fail_q <= !match_q;
                pass_q <= match_q;
                pins_q.vpp <= RAIL_OFF;
                st_q <= S_VPP_OFF;
              end else begin
                pins_q.addr <= pins_q.addr + `OPP_AW'(1);
                st_q <= S_OES;
              end
            end
          endcase
        end
        S_VPP_DN: if (fire) begin
          pins_q.vcc <= RAIL_NORM;
          ld_q <= 1'b1;
          ld_cnt_q <= SU_LD;
          st_q <= S_VCC_DN;
        end
        S_VCC_DN: if (fire) begin
          pins_q.addr <= '0;
          ld_q <= 1'b1;
          ld_cnt_q <= SU_LD;
          st_q <= S_OES;
        end
        S_VPP_OFF: if (fire) begin
          pins_q.vcc <= RAIL_OFF;
          ld_q <= 1'b1;
          ld_cnt_q <= SU_LD;
          st_q <= S_VCC_OFF;
        end
        S_VCC_OFF: if (fire) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [TW-1:0] ce_low_q;
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ce_low_q <= '0;
    end else begin
      ce_low_q <= pins_q.ce_n ? '0 : ce_low_q + TW'(1);
    end
  end

  property p_pw_len;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      ($rose(pins_q.ce_n) && phase_q != PH_ID && phase_q != PH_FINAL)
        |-> ($past(ce_low_q) >= TW'(PW_MIN_CYC) && $past(ce_low_q) <= TW'(PW_MAX_CYC));
  endproperty
  a_pw_len: assert property (p_pw_len) else $error("program pulse out of window");

  property p_prog_rails;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      ($fell(pins_q.ce_n) && pins_q.dq_oe) |-> (pins_q.vcc == RAIL_PROG && pins_q.vpp == RAIL_PROG);
  endproperty
  a_prog_rails: assert property (p_prog_rails) else $error("pulse without program rails");

  property p_no_read_first;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (busy_q && phase_q == PH_FIRST) |-> pins_q.oe_n;
  endproperty
  a_no_read_first: assert property (p_no_read_first) else $error("read in first pass");

  property p_retry_pulse;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (st_q == S_FLT && fire && phase_q == PH_VERIFY && !match_q && !retry_out_w)
        |=> (st_q == S_SET && retry_q == $past(retry_q) + `OPP_RETRY_W'(1));
  endproperty
  a_retry_pulse: assert property (p_retry_pulse) else $error("missed re-pulse");

  property p_fail_stop;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (st_q == S_FLT && fire && phase_q == PH_VERIFY && !match_q && retry_q == `OPP_RETRY_MAX)
        |=> (fail_q && st_q == S_VPP_OFF && pins_q.vpp == RAIL_OFF);
  endproperty
  a_fail_stop: assert property (p_fail_stop) else $error("part not failed");

  property p_hold_addr;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      // the jump back to the first address when the verify pass opens is no advance
      (phase_q == PH_VERIFY && $past(phase_q) == PH_VERIFY && $changed(pins_q.addr))
        |-> $past(match_q);
  endproperty
  a_hold_addr: assert property (p_hold_addr) else $error("advanced on bad byte");

  property p_final_rails;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (phase_q == PH_FINAL && !pins_q.oe_n) |-> (pins_q.vcc == RAIL_NORM && pins_q.vpp == RAIL_NORM);
  endproperty
  a_final_rails: assert property (p_final_rails) else $error("final read at wrong rails");

  property p_rail_order;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (pins_q.vpp != RAIL_OFF) |-> (pins_q.vcc != RAIL_OFF && (pins_q.vpp != RAIL_PROG || pins_q.vcc == RAIL_PROG));
  endproperty
  a_rail_order: assert property (p_rail_order) else $error("rail ahead of core supply");

  property p_oe_read;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      $fell(pins_q.oe_n) |-> !pins_q.oe_n [*8] ##1 (pins_q.oe_n && !pins_q.dq_oe) [*6];
  endproperty
  a_oe_read: assert property (p_oe_read) else $error("read or float window short");

  property p_id_hv;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (phase_q == PH_ID && !pins_q.oe_n) |-> (pins_q.id_hv && pins_q.vcc == RAIL_NORM);
  endproperty
  a_id_hv: assert property (p_id_hv) else $error("id read without high voltage");

  property p_retry_clr;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (phase_q == PH_VERIFY && $changed(pins_q.addr)) |-> (retry_q == '0);
  endproperty
  a_retry_clr: assert property (p_retry_clr) else $error("retry count not cleared");
endmodule

// [design/opp_timer.sv]
`timescale 1ns/1ps
`include "opp_map.svh"
module opp_timer #(
  parameter int CW = `OPP_TMR_W
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // control
  input wire logic i_load,
  input wire logic [CW-1:0] i_count,
  output logic o_fire
);
  logic [CW-1:0] cnt_q;

  assign o_fire = (cnt_q == CW'(1)) && !i_load;

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_q <= '0;
    end else if (i_load) begin
      cnt_q <= i_count;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - CW'(1);
    end
  end
endmodule

// [inc/opp_map.svh]
`ifndef OPP_MAP_SVH
`define OPP_MAP_SVH
`define OPP_AW 15
`define OPP_DW 8
`define OPP_CLK_NS 25
`define OPP_PW_NS 100000
`define OPP_PW_MIN_NS 95000
`define OPP_PW_MAX_NS 105000
`define OPP_SETUP_NS 2000
`define OPP_OE_NS 150
`define OPP_DFP_NS 130
`define OPP_SYNC_CYC 2
`define OPP_RETRY_MAX 4'ha
`define OPP_RETRY_W 4
`define OPP_TMR_W 13
`define OPP_CODE_SEL_BIT 0
`endif

// [inc/opp_pkg.sv]
`include "opp_map.svh"
package opp_pkg;
  typedef enum logic [1:0] {RAIL_OFF, RAIL_NORM, RAIL_PROG} opp_rail_t;
  typedef enum logic [1:0] {PH_FIRST, PH_VERIFY, PH_FINAL, PH_ID} opp_phase_t;
  // pins toward the part; vcc prog is 6.5V, vpp prog 13.0V, norm 5.0V
  typedef struct packed {
    logic [`OPP_AW-1:0] addr;
    logic ce_n;
    logic oe_n;
    logic [`OPP_DW-1:0] dq_out;
    logic dq_oe;
    opp_rail_t vcc;
    opp_rail_t vpp;
    logic id_hv;
  } opp_pins_t;
  // least time, rounded up to whole cycles
  function automatic int opp_cyc_up(input int ns);
    return (ns + `OPP_CLK_NS - 1) / `OPP_CLK_NS;
  endfunction
  // longest time, rounded down
  function automatic int opp_cyc_dn(input int ns);
    return ns / `OPP_CLK_NS;
  endfunction
endpackage

// [verif/opp_otp_model.sv]
`timescale 1ns/1ps
`include "opp_map.svh"
module opp_otp_model
  import opp_pkg::*;
#(
  parameter int N_ADDR = 2,
  parameter logic [`OPP_DW-1:0] MFR_CODE = 8'h5a, // arbitrary value
  parameter logic [`OPP_DW-1:0] DEV_CODE = 8'hc3 // arbitrary value
) (
  // bench control
  input wire logic i_blank,
  input wire logic i_slow,
  input wire logic [`OPP_AW-1:0] i_weak_addr,
  input wire logic [4:0] i_weak_need,
  // part pins
  input wire opp_pins_t i_pins,
  output logic [`OPP_DW-1:0] o_dq
);
  logic [`OPP_DW-1:0] mem [N_ADDR];
  int pulses [N_ADDR];
  int rule_errs = 0;
  int run_pulses = 0;
  int final_reads = 0;
  bit read_since_pulse = 0;
  realtime t_fall = 0;
  wire verify_rd = (i_pins.vpp == RAIL_PROG);
  wire [`OPP_DW-1:0] code = i_pins.addr[`OPP_CODE_SEL_BIT] ? DEV_CODE : MFR_CODE;
  wire [`OPP_DW-1:0] val = i_pins.id_hv ? code : mem[i_pins.addr];

  initial o_dq = 8'h00;

  always @(posedge i_blank) begin
    foreach (mem[a]) begin
      mem[a] = 8'hff;
      pulses[a] = 0;
    end
    run_pulses = 0;
    final_reads = 0;
  end

  ////////////////////////////////////////////////////////////////////////
  // enum order off < norm < prog, so vpp never above vcc
  always @(i_pins.vcc or i_pins.vpp) if (i_pins.vpp > i_pins.vcc) rule_errs++;

  always @(negedge i_pins.ce_n) t_fall = $realtime;

  always @(posedge i_pins.ce_n) if (verify_rd && i_pins.oe_n) begin
    if ($realtime - t_fall < 95000 || $realtime - t_fall > 105000) rule_errs++;
    if (i_pins.vcc != RAIL_PROG || !i_pins.dq_oe) rule_errs++;
    if (run_pulses < N_ADDR && i_pins.addr != run_pulses) rule_errs++;
    // a re-pulse needs a failed verify in between
    if (run_pulses >= N_ADDR && (!read_since_pulse || mem[i_pins.addr] == i_pins.dq_out))
      rule_errs++;
    run_pulses++;
    read_since_pulse = 0;
    pulses[i_pins.addr]++;
    if (pulses[i_pins.addr] > 11) rule_errs++;
    // a weak byte only takes after enough pulses
    if (i_pins.addr != i_weak_addr || pulses[i_pins.addr] >= i_weak_need)
      mem[i_pins.addr] = i_pins.dq_out;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs show changing garbage until valid and after float
  always @(i_pins.oe_n) begin
    if (!i_pins.oe_n) begin
      if (verify_rd && run_pulses < N_ADDR) rule_errs++;
      if (verify_rd) read_since_pulse = 1;
      if (!i_pins.ce_n && !i_pins.id_hv && i_pins.vcc == RAIL_NORM && i_pins.vpp == RAIL_NORM)
        final_reads++;
      o_dq = ~o_dq;
      #(i_slow ? 145 : 20);
      if (!i_pins.oe_n && (!i_pins.ce_n || verify_rd)) o_dq = val;
    end else begin
      #130 o_dq = ~o_dq;
    end
  end
endmodule

// [verif/opp_prog_tb.sv]
`timescale 1ns/1ps
`include "opp_map.svh"
module opp_prog_tb;
  import opp_pkg::*;
  localparam int LIMIT = 95000;
  logic i_ref_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_prog_start = 1'b0;
  logic i_id_start = 1'b0;
  logic [7:0] i_src_data = 8'h00;
  logic o_busy, o_done, o_pass, o_fail;
  logic [7:0] o_mfr_code, o_dev_code, dev_dq;
  opp_pins_t o_pins;
  logic blank = 1'b0;
  logic slow = 1'b0;
  logic [14:0] weak_addr = 15'h0000;
  logic [4:0] weak_need = 5'h01;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  // our own drive wins the shared data pins
  wire [7:0] i_dq = o_pins.dq_oe ? o_pins.dq_out : dev_dq;

  always #12.5 i_ref_clk = ~i_ref_clk;

  opp_prog #(.LAST_ADDR(15'h0001), .PW_NS(100000), .SETUP_NS(100)) i_dut (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_prog_start(i_prog_start),
    .i_id_start(i_id_start), .i_src_data(i_src_data), .o_busy(o_busy), .o_done(o_done),
    .o_pass(o_pass), .o_fail(o_fail), .o_mfr_code(o_mfr_code), .o_dev_code(o_dev_code),
    .i_dq(i_dq), .o_pins(o_pins));

  opp_otp_model #(.N_ADDR(2)) i_dev (
    .i_blank(blank), .i_slow(slow), .i_weak_addr(weak_addr), .i_weak_need(weak_need),
    .i_pins(o_pins), .o_dq(dev_dq));

  function automatic logic [7:0] src_of(input logic [14:0] a);
    return 8'h3c ^ a[7:0];
  endfunction

  always @(negedge i_ref_clk) i_src_data <= src_of(o_pins.addr);

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // a second start while busy must be ignored
  task automatic run(input logic prog, input logic id);
    int n;
    @(negedge i_ref_clk);
    i_prog_start = prog;
    i_id_start = id;
    @(negedge i_ref_clk);
    check("busy", o_busy, 1'b1);
    i_prog_start = 1'b0;
    i_id_start = prog;
    @(negedge i_ref_clk);
    i_id_start = 1'b0;
    n = 0;
    while (o_done !== 1'b1 && n < 70000) begin
      @(negedge i_ref_clk);
      n++;
    end
    check("done", o_done, 1'b1);
  endtask

  task automatic new_part(input logic [14:0] wa, input logic [4:0] wn, input logic sl);
    weak_addr = wa;
    weak_need = wn;
    slow = sl;
    blank = 1'b1;
    @(negedge i_ref_clk);
    blank = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    check("idle pins", {o_pins.ce_n, o_pins.oe_n, o_pins.dq_oe, o_pins.id_hv, o_pins.vcc,
      o_pins.vpp}, {4'b1100, RAIL_OFF, RAIL_OFF});
    check("idle addr", o_pins.addr, 15'h0000);
    check("idle flags", {o_busy, o_done, o_pass, o_fail}, 4'h0);
    $display("test reset done");
  endtask

  // slow part, byte 1 needs two extra pulses
  task automatic test_pass();
    new_part(15'h0001, 5'd3, 1'b1);
    run(1'b1, 1'b0);
    check("pass", {o_pass, o_fail}, 2'b10);
    check("pulses 0", i_dev.pulses[0], 1);
    check("pulses 1", i_dev.pulses[1], 3);
    check("final reads", i_dev.final_reads, 2);
    check("byte 0", i_dev.mem[0], src_of(15'h0000));
    check("byte 1", i_dev.mem[1], src_of(15'h0001));
    check("part rules", i_dev.rule_errs, 0);
    check("no id", o_mfr_code, 8'h00);
    check("rails off", {o_pins.vcc, o_pins.vpp}, {RAIL_OFF, RAIL_OFF});
    $display("test pass done");
  endtask

  // byte 0 never takes; both starts raised at once
  task automatic test_fail();
    new_part(15'h0000, 5'h1f, 1'b0);
    run(1'b1, 1'b1);
    check("fail", {o_pass, o_fail}, 2'b01);
    check("pulses 0", i_dev.pulses[0], 11);
    check("pulses 1", i_dev.pulses[1], 1);
    check("no final", i_dev.final_reads, 0);
    check("part rules", i_dev.rule_errs, 0);
    check("no id", o_mfr_code, 8'h00);
    check("rails off", {o_pins.vcc, o_pins.vpp}, {RAIL_OFF, RAIL_OFF});
    $display("test fail done");
  endtask

  task automatic test_id();
    new_part(15'h0000, 5'h01, 1'b0);
    run(1'b0, 1'b1);
    check("id pass", {o_pass, o_fail}, 2'b10);
    check("maker", o_mfr_code, 8'h5a);
    check("type", o_dev_code, 8'hc3);
    check("part rules", i_dev.rule_errs, 0);
    check("id off", {o_pins.id_hv, o_pins.vcc, o_pins.vpp}, {1'b0, RAIL_OFF, RAIL_OFF});
    $display("test id done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // whole run is about 65k cycles
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    repeat (20) @(posedge i_ref_clk);
    test_reset();
    @(negedge i_ref_clk);
    i_sys_rst = 1'b0;
    test_pass();
    test_fail();
    test_id();
    give_verdict();
  end
endmodule
